// ### led_xover_regs.sv
// Contract
// - The second indicator has a 4-bit read/write selector defaulting to 1h, any activity.
// - The first indicator has a 4-bit read/write selector defaulting to 0h, link OK.
// - Selector codes 0 to 7 pick link, activity, transmit, receive, collision, 100M, 10M and full duplex.
// - Selector code 8 lights steadily on link and blinks on receive or transmit activity.
// - A read/write parallel-detect bit, default 1, lets crossover run with local negotiation off.
// - A read/write auto-switch bit, default 1, turns automatic crossover on.
// - The pair bit, default 0, reads 1 for crossed pairs and 0 for straight pairs.
// - With auto-switch on the pair bit is read-only and shows the chosen configuration.
// - With auto-switch off a write to the pair bit forces that configuration.
// - The completion bit reads 1 once switching has settled, else 0, and 0 with auto-switch off.
// - A 4-bit read/write seed gives the starting pattern of the switching sequence.
// - A seed of zero is replaced by the internal seed 0101.
//
// Purpose: Indicator select and crossover control registers with their logic
// Assumes: Serial management engine presents decoded register reads and writes
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/10ps
module led_xover_regs #(
	parameter int BLINK_HALF_CYCLES_P = led_xover_pkg::BLINK_HALF_CYCLES,
	parameter int ATTEMPT_CYCLES_P    = led_xover_pkg::ATTEMPT_CYCLES
) (
	input  wire logic                            clk_in,
	input  wire logic                            reset_n_in,
	input  wire logic [4:0]                      reg_addr_in,
	input  wire logic                            reg_wr_in,
	input  wire logic                            reg_rd_in,
	input  wire logic [led_xover_pkg::REG_W-1:0] reg_wdata_in,
	output logic      [led_xover_pkg::REG_W-1:0] reg_rdata_out,
	output logic                                 reg_rvalid_out,
	input  wire logic                            link_ok_in,
	input  wire logic                            tx_activity_in,
	input  wire logic                            rx_activity_in,
	input  wire logic                            collision_in,
	input  wire logic                            speed_100_in,
	input  wire logic                            full_duplex_in,
	input  wire logic                            local_aneg_enable_in,
	input  wire logic                            partner_aneg_in,
	output logic                                 first_indicator_out,
	output logic                                 second_indicator_out,
	output logic                                 pair_crossed_out
);
	import led_xover_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [SEL_W-1:0]  first_indicator_select;
	logic [SEL_W-1:0]  second_indicator_select;
	logic              parallel_detect_assist;
	logic              crossover_auto_enable;
	logic              pair_crossed_state;
	logic [SEED_W-1:0] crossover_seed;
	logic [SEL_W-1:0]  next_first_indicator_select;
	logic [SEL_W-1:0]  next_second_indicator_select;
	logic              next_parallel_detect_assist;
	logic              next_crossover_auto_enable;
	logic [SEED_W-1:0] next_crossover_seed;
	logic [REG_W-1:0]  rdata;
	logic [REG_W-1:0]  next_rdata;
	logic              rvalid;
	logic              crossover_sequence_done;
	logic              wr_indicator;
	logic              wr_crossover;

	assign wr_indicator = reg_wr_in && (reg_addr_in == INDICATOR_SELECT_ADDR);
	assign wr_crossover = reg_wr_in && (reg_addr_in == CROSSOVER_CONTROL_ADDR);

	always_comb begin
		next_first_indicator_select  = first_indicator_select;
		next_second_indicator_select = second_indicator_select;
		next_parallel_detect_assist  = parallel_detect_assist;
		next_crossover_auto_enable   = crossover_auto_enable;
		next_crossover_seed          = crossover_seed;
		// Upper byte of the indicator register is not stored
		if (wr_indicator) begin
			next_second_indicator_select = reg_wdata_in[SECOND_SEL_LSB +: SEL_W];
			next_first_indicator_select  = reg_wdata_in[FIRST_SEL_LSB +: SEL_W];
		end
		if (wr_crossover) begin
			next_parallel_detect_assist = reg_wdata_in[PD_BIT];
			next_crossover_auto_enable  = reg_wdata_in[AUTO_BIT];
			next_crossover_seed         = reg_wdata_in[SEED_LSB +: SEED_W];
		end
		next_rdata = READ_ZERO;
		if (reg_addr_in == INDICATOR_SELECT_ADDR) begin
			next_rdata[SECOND_SEL_LSB +: SEL_W] = second_indicator_select;
			next_rdata[FIRST_SEL_LSB +: SEL_W]  = first_indicator_select;
		end else if (reg_addr_in == CROSSOVER_CONTROL_ADDR) begin
			next_rdata[PD_BIT]                = parallel_detect_assist;
			next_rdata[AUTO_BIT]              = crossover_auto_enable;
			next_rdata[PAIR_BIT]              = pair_crossed_state;
			next_rdata[DONE_BIT]              = crossover_sequence_done;
			next_rdata[SEED_LSB +: SEED_W]    = crossover_seed;
		end
		if (!reg_rd_in) begin
			next_rdata = rdata;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			first_indicator_select  <= FIRST_SEL_RESET;
			second_indicator_select <= SECOND_SEL_RESET;
			parallel_detect_assist  <= PD_RESET;
			crossover_auto_enable   <= AUTO_RESET;
			crossover_seed          <= SEED_RESET;
			rdata                   <= READ_ZERO;
			rvalid                  <= 1'b0;
		end else begin
			first_indicator_select  <= next_first_indicator_select;
			second_indicator_select <= next_second_indicator_select;
			parallel_detect_assist  <= next_parallel_detect_assist;
			crossover_auto_enable   <= next_crossover_auto_enable;
			crossover_seed          <= next_crossover_seed;
			rdata                   <= next_rdata;
			rvalid                  <= reg_rd_in;
		end
	end

	assign reg_rdata_out  = rdata;
	assign reg_rvalid_out = rvalid;

	// ----------------------------------------
	// Blink timer and activity stretch
	// ----------------------------------------
	logic [TIMER_W-1:0] blink_cnt;
	logic [TIMER_W-1:0] next_blink_cnt;
	logic               blink_phase;
	logic               next_blink_phase;
	logic               blink_tick;
	logic               tx_hold;
	logic               rx_hold;
	logic               next_tx_hold;
	logic               next_rx_hold;

	assign blink_tick = (blink_cnt == TIMER_W'(BLINK_HALF_CYCLES_P - 1));

	always_comb begin
		next_blink_cnt   = blink_tick ? '0 : blink_cnt + TIMER_W'(1);
		next_blink_phase = blink_tick ? ~blink_phase : blink_phase;
		// Activity sets the hold; a tick clears it unless activity is present
		next_tx_hold     = tx_activity_in | (tx_hold & ~blink_tick);
		next_rx_hold     = rx_activity_in | (rx_hold & ~blink_tick);
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			blink_cnt   <= '0;
			blink_phase <= 1'b0;
			tx_hold     <= 1'b0;
			rx_hold     <= 1'b0;
		end else begin
			blink_cnt   <= next_blink_cnt;
			blink_phase <= next_blink_phase;
			tx_hold     <= next_tx_hold;
			rx_hold     <= next_rx_hold;
		end
	end

	// ----------------------------------------
	// Indicator outputs
	// ----------------------------------------
	indicator_mux first_mux (
		.clk_in         (clk_in),
		.reset_n_in     (reset_n_in),
		.sel_in         (first_indicator_select),
		.link_ok_in     (link_ok_in),
		.tx_hold_in     (tx_hold),
		.rx_hold_in     (rx_hold),
		.collision_in   (collision_in),
		.speed_100_in   (speed_100_in),
		.full_duplex_in (full_duplex_in),
		.blink_phase_in (blink_phase),
		.led_out        (first_indicator_out)
	);

	indicator_mux second_mux (
		.clk_in         (clk_in),
		.reset_n_in     (reset_n_in),
		.sel_in         (second_indicator_select),
		.link_ok_in     (link_ok_in),
		.tx_hold_in     (tx_hold),
		.rx_hold_in     (rx_hold),
		.collision_in   (collision_in),
		.speed_100_in   (speed_100_in),
		.full_duplex_in (full_duplex_in),
		.blink_phase_in (blink_phase),
		.led_out        (second_indicator_out)
	);

	// ----------------------------------------
	// Crossover switching
	// ----------------------------------------
	xover_state_t       state;
	xover_state_t       next_state;
	logic [TIMER_W-1:0] slot_cnt;
	logic [TIMER_W-1:0] next_slot_cnt;
	logic [SEED_W-1:0]  lfsr;
	logic [SEED_W-1:0]  next_lfsr;
	logic               next_pair_crossed_state;
	logic               switch_active;
	logic               slot_end;

	// Negotiation off locally but on at the partner needs parallel detect
	assign switch_active = crossover_auto_enable &&
		(local_aneg_enable_in || !partner_aneg_in || parallel_detect_assist);
	assign slot_end = (slot_cnt == TIMER_W'(ATTEMPT_CYCLES_P - 1));
	assign crossover_sequence_done = crossover_auto_enable && (state == XS_LINKED);

	always_comb begin
		next_state              = state;
		next_slot_cnt           = slot_cnt;
		next_lfsr               = lfsr;
		next_pair_crossed_state = pair_crossed_state;
		if (!crossover_auto_enable && wr_crossover) begin
			next_pair_crossed_state = reg_wdata_in[PAIR_BIT];
		end
		case (state)
			XS_OFF: begin
				if (switch_active) begin
					next_state    = XS_WAIT;
					next_slot_cnt = '0;
					next_lfsr     = (crossover_seed == SEED_RESET) ? DEFAULT_SEED : crossover_seed;
				end
			end
			XS_WAIT: begin
				if (!switch_active) begin
					next_state = XS_OFF;
				end else if (link_ok_in) begin
					next_state = XS_LINKED;
				end else if (slot_end) begin
					next_state    = XS_TRY;
					next_slot_cnt = '0;
				end else begin
					next_slot_cnt = slot_cnt + TIMER_W'(1);
				end
			end
			XS_TRY: begin
				// Seed pattern decides whether this attempt swaps the pairs
				next_pair_crossed_state = pair_crossed_state ^ lfsr[SEED_W-1];
				next_lfsr               = {lfsr[SEED_W-2:0], lfsr[SEED_W-1] ^ lfsr[SEED_W-2]};
				next_state              = switch_active ? XS_WAIT : XS_OFF;
			end
			XS_LINKED: begin
				if (!switch_active) begin
					next_state = XS_OFF;
				end else if (!link_ok_in) begin
					next_state    = XS_WAIT;
					next_slot_cnt = '0;
				end
			end
			default: next_state = XS_OFF;
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state              <= XS_OFF;
			slot_cnt           <= '0;
			lfsr               <= DEFAULT_SEED;
			pair_crossed_state <= PAIR_RESET;
		end else begin
			state              <= next_state;
			slot_cnt           <= next_slot_cnt;
			lfsr               <= next_lfsr;
			pair_crossed_state <= next_pair_crossed_state;
		end
	end

	assign pair_crossed_out = pair_crossed_state;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence xover_write_s;
		reg_wr_in && (reg_addr_in == CROSSOVER_CONTROL_ADDR);
	endsequence

	sequence forced_write_s;
		xover_write_s and !crossover_auto_enable;
	endsequence

	reset_defaults_a: assert property (@(posedge clk_in) $rose(reset_n_in) |->
		first_indicator_select == 4'h0 && second_indicator_select == 4'h1 && !pair_crossed_state)
		else $error("Register defaults wrong after reset");

	select_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		wr_indicator |=> second_indicator_select == $past(reg_wdata_in[7:4]) &&
		first_indicator_select == $past(reg_wdata_in[3:0]))
		else $error("Indicator selector write lost");

	control_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		xover_write_s |=> crossover_auto_enable == $past(reg_wdata_in[6]) &&
		parallel_detect_assist == $past(reg_wdata_in[7]) && crossover_seed == $past(reg_wdata_in[3:0]))
		else $error("Crossover control write lost");

	pair_force_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		forced_write_s |=> pair_crossed_state == $past(reg_wdata_in[5]))
		else $error("Pair force write not applied");

	pair_readonly_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		($changed(pair_crossed_state) && $past(crossover_auto_enable)) |-> $past(state) == XS_TRY)
		else $error("Pair bit changed outside a switching attempt");

	done_report_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_rd_in && reg_addr_in == CROSSOVER_CONTROL_ADDR && !crossover_auto_enable) |=> !reg_rdata_out[4])
		else $error("Completion reads set with auto-switch off");

	done_link_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(state == XS_WAIT && switch_active && link_ok_in) ##1 crossover_auto_enable |-> crossover_sequence_done)
		else $error("Completion not reported after link");

	seed_default_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(state == XS_OFF && switch_active && crossover_seed == 4'h0) |=> lfsr == 4'h5)
		else $error("Zero seed not replaced");

	blink_period_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$changed(blink_phase) |-> $past(blink_cnt) == TIMER_W'(BLINK_HALF_CYCLES_P - 1))
		else $error("Blink phase moved off period");

	blink_mode_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(first_indicator_select == 4'h8 && link_ok_in && !tx_hold && !rx_hold) |=> first_indicator_out)
		else $error("Link with blink mode not lit on idle link");

	collision_mode_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(second_indicator_select == 4'h4) |=> second_indicator_out == $past(collision_in))
		else $error("Collision selector decode wrong");

endmodule

// ### led_xover_pkg.sv
// Purpose: Shared constants and types for the indicator and crossover register bank
// Assumes: 50 MHz oscillator clock, 5-bit management register address
// Notes:   Register offsets, field positions, reset values and timing counts
package led_xover_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [4:0] INDICATOR_SELECT_ADDR  = 5'h17;
	localparam logic [4:0] CROSSOVER_CONTROL_ADDR = 5'h18;
	localparam int         REG_W                  = 16;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SECOND_SEL_LSB = 4;
	localparam int FIRST_SEL_LSB  = 0;
	localparam int SEL_W          = 4;
	localparam int PD_BIT         = 7;
	localparam int AUTO_BIT       = 6;
	localparam int PAIR_BIT       = 5;
	localparam int DONE_BIT       = 4;
	localparam int SEED_LSB       = 0;
	localparam int SEED_W         = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0]  SECOND_SEL_RESET = 4'h1;
	localparam logic [3:0]  FIRST_SEL_RESET  = 4'h0;
	localparam logic        PD_RESET         = 1'b1;
	localparam logic        AUTO_RESET       = 1'b1;
	localparam logic        PAIR_RESET       = 1'b0;
	localparam logic [3:0]  SEED_RESET       = 4'h0;
	localparam logic [3:0]  DEFAULT_SEED     = 4'h5;
	localparam logic [15:0] READ_ZERO        = 16'h0000;

	// ----------------------------------------
	// Indicator selector codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		IND_LINK      = 4'h0,
		IND_ACTIVITY  = 4'h1,
		IND_TX        = 4'h2,
		IND_RX        = 4'h3,
		IND_COLLISION = 4'h4,
		IND_SPEED_100 = 4'h5,
		IND_SPEED_10  = 4'h6,
		IND_FULL_DPLX = 4'h7,
		IND_LINK_BLINK = 4'h8
	} ind_sel_t;

	// ----------------------------------------
	// Crossover states
	// ----------------------------------------
	typedef enum logic [1:0] {
		XS_OFF    = 2'b10,
		XS_WAIT   = 2'b00,
		XS_TRY    = 2'b01,
		XS_LINKED = 2'b11
	} xover_state_t;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_FREQ_HZ       = 50_000_000;
	localparam int BLINK_HALF_MS     = 50;
	localparam int BLINK_HALF_CYCLES = CLK_FREQ_HZ / 1000 * BLINK_HALF_MS;
	localparam int ATTEMPT_MS        = 64;
	localparam int ATTEMPT_CYCLES    = CLK_FREQ_HZ / 1000 * ATTEMPT_MS;
	localparam int RESET_MIN_CYCLES  = 30;
	localparam int TIMER_W           = 22;

endpackage

// ### indicator_mux.sv
// Purpose: Drives one indicator output from its selector code
// Assumes: Status inputs synchronous to clk_in, activity already stretched
// Notes:   Codes above the link-with-blink code leave the indicator dark
`timescale 1ns/10ps
module indicator_mux (
	input  wire logic                            clk_in,
	input  wire logic                            reset_n_in,
	input  wire logic [led_xover_pkg::SEL_W-1:0] sel_in,
	input  wire logic                            link_ok_in,
	input  wire logic                            tx_hold_in,
	input  wire logic                            rx_hold_in,
	input  wire logic                            collision_in,
	input  wire logic                            speed_100_in,
	input  wire logic                            full_duplex_in,
	input  wire logic                            blink_phase_in,
	output logic                                 led_out
);
	import led_xover_pkg::*;

	logic next_led;
	logic led;

	// ----------------------------------------
	// Selector decode
	// ----------------------------------------
	always_comb begin
		case (sel_in)
			IND_LINK:       next_led = link_ok_in;
			IND_ACTIVITY:   next_led = tx_hold_in | rx_hold_in;
			IND_TX:         next_led = tx_hold_in;
			IND_RX:         next_led = rx_hold_in;
			IND_COLLISION:  next_led = collision_in;
			IND_SPEED_100:  next_led = speed_100_in;
			IND_SPEED_10:   next_led = ~speed_100_in;
			IND_FULL_DPLX:  next_led = full_duplex_in;
			IND_LINK_BLINK: next_led = link_ok_in & ~((tx_hold_in | rx_hold_in) & blink_phase_in);
			default:        next_led = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			led <= 1'b0;
		end else begin
			led <= next_led;
		end
	end

	assign led_out = led;

endmodule

// ### mgmt_master_model.sv
// Purpose: Management master model driving the decoded register port
// Assumes: A request is taken at the rising edge where its strobe is high
// Notes:   Address lines show the inverse of the last request when idle, data lines only after a write
`timescale 1ns/10ps
module mgmt_master_model (
	input  wire logic                            clk_in,
	output logic      [4:0]                      reg_addr_out,
	output logic                                 reg_wr_out,
	output logic                                 reg_rd_out,
	output logic      [led_xover_pkg::REG_W-1:0] reg_wdata_out,
	input  wire logic [led_xover_pkg::REG_W-1:0] reg_rdata_in,
	input  wire logic                            reg_rvalid_in
);
	import led_xover_pkg::*;

	initial begin
		reg_addr_out  = 5'h00;
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
		reg_wdata_out = 16'h0000;
	end

	// ----------------------------------------
	// Register write, one strobe cycle
	// ----------------------------------------
	task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
		@(posedge clk_in);
		reg_addr_out  <= addr;
		reg_wdata_out <= (addr == INDICATOR_SELECT_ADDR) ? {8'h00, data[7:0]} : data;
		reg_wr_out    <= 1'b1;
		@(posedge clk_in);
		reg_wr_out    <= 1'b0;
		reg_addr_out  <= ~addr;
		reg_wdata_out <= ~data;
	endtask

	// ----------------------------------------
	// Register read, answer one cycle later
	// ----------------------------------------
	task automatic read_reg(input logic [4:0] addr, output logic [15:0] data, output logic ok);
		@(posedge clk_in);
		reg_addr_out <= addr;
		reg_rd_out   <= 1'b1;
		@(posedge clk_in);
		reg_rd_out   <= 1'b0;
		reg_addr_out <= ~addr;
		#1;
		ok   = reg_rvalid_in;
		data = reg_rdata_in;
	endtask
endmodule

// ### led_select_and_crossover_control_tb.sv
// Purpose: Self-checking bench for the indicator and crossover registers
// Assumes: Short blink and attempt counts of 8 cycles
// Notes:   Decode cases run from a table, the rest by hand
`timescale 1ns/10ps
module led_select_and_crossover_control_tb;
	import led_xover_pkg::*;

	logic        clk, reset_n, link_ok, tx_act, rx_act, col, spd, fdx, lan, pan;
	logic [4:0]  addr;
	logic        wr, rd, rvalid, first, second, pair, ok, saw0, saw1;
	logic [15:0] wdata, rdata, d;
	int          err_count, check_count;
	logic [11:0] rows [19] = '{12'h081, 12'h000, 12'h141, 12'h100, 12'h241, 12'h220, 12'h321, 12'h340,
		12'h411, 12'h400, 12'h509, 12'h500, 12'h601, 12'h608, 12'h705, 12'h700, 12'h881, 12'h800, 12'h9FC};

	always #10 clk = ~clk;

	mgmt_master_model u_master (.clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));

	led_xover_regs #(.BLINK_HALF_CYCLES_P(8), .ATTEMPT_CYCLES_P(8)) u_dut (.clk_in(clk),
		.reset_n_in(reset_n), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .link_ok_in(link_ok), .tx_activity_in(tx_act),
		.rx_activity_in(rx_act), .collision_in(col), .speed_100_in(spd), .full_duplex_in(fdx),
		.local_aneg_enable_in(lan), .partner_aneg_in(pan), .first_indicator_out(first),
		.second_indicator_out(second), .pair_crossed_out(pair));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] mask);
		u_master.read_reg(a, d, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(d & mask, exp);
	endtask

	task automatic set_in(input logic [5:0] v);
		@(posedge clk);
		{link_ok, tx_act, rx_act, col, spd, fdx} <= v;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		wrap_up;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		{link_ok, tx_act, rx_act, col, spd, fdx} = 6'h00;
		lan = 1'b1;
		pan = 1'b0;
		err_count = 0;
		check_count = 0;
		repeat (30) @(posedge clk);
		reset_n <= 1'b1;
		rd_chk(INDICATOR_SELECT_ADDR, 16'h0010, 16'hFFFF);
		rd_chk(CROSSOVER_CONTROL_ADDR, 16'h00C0, 16'hFFFF);
		$display("Test reset values done");
		foreach (rows[i]) begin
			u_master.write_reg(INDICATOR_SELECT_ADDR, {8'h00, rows[i][11:8], rows[i][11:8]});
			set_in(rows[i][7:2]);
			wait_cyc(20);
			chk({14'h0000, first, second}, {14'h0000, rows[i][0], rows[i][0]});
		end
		$display("Test selector decode done");
		u_master.write_reg(INDICATOR_SELECT_ADDR, 16'h0088);
		set_in(6'h30);
		saw0 = 1'b0;
		saw1 = 1'b0;
		repeat (40) begin
			wait_cyc(1);
			saw0 = saw0 | (first === 1'b0);
			saw1 = saw1 | (first === 1'b1);
		end
		chk({14'h0000, saw1, saw0}, 16'h0003);
		u_master.write_reg(5'h10, 16'hFFFF);
		rd_chk(5'h10, 16'h0000, 16'hFFFF);
		rd_chk(INDICATOR_SELECT_ADDR, 16'h0088, 16'hFFFF);
		$display("Test blink and unmapped done");
		set_in(6'h00);
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h0080);
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h00A0);
		rd_chk(CROSSOVER_CONTROL_ADDR, 16'h00A0, 16'hFFFF);
		chk({15'h0000, pair}, 16'h0001);
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h0080);
		rd_chk(CROSSOVER_CONTROL_ADDR, 16'h0080, 16'hFFFF);
		chk({15'h0000, pair}, 16'h0000);
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h00C0);
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h00E0);
		rd_chk(CROSSOVER_CONTROL_ADDR, 16'h00C0, 16'hFFFF);
		wait_cyc(8);
		chk({15'h0000, pair}, 16'h0000);
		wait_cyc(8);
		chk({15'h0000, pair}, 16'h0001);
		$display("Test forced and read-only pair done");
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h0080);
		@(posedge clk);
		lan <= 1'b0;
		pan <= 1'b1;
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h0048);
		wait_cyc(14);
		chk({15'h0000, pair}, 16'h0000);
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h00C8);
		wait_cyc(12);
		chk({15'h0000, pair}, 16'h0001);
		rd_chk(CROSSOVER_CONTROL_ADDR, 16'h00E8, 16'h00EF);
		set_in(6'h20);
		wait_cyc(4);
		rd_chk(CROSSOVER_CONTROL_ADDR, 16'h00F8, 16'hFFFF);
		u_master.write_reg(CROSSOVER_CONTROL_ADDR, 16'h0088);
		rd_chk(CROSSOVER_CONTROL_ADDR, 16'h00A8, 16'hFFFF);
		$display("Test seed and completion done");
		@(posedge clk);
		reset_n <= 1'b0;
		wait_cyc(2);
		chk({13'h0000, first, second, pair}, 16'h0000);
		repeat (28) @(posedge clk);
		reset_n <= 1'b1;
		rd_chk(INDICATOR_SELECT_ADDR, 16'h0010, 16'hFFFF);
		rd_chk(CROSSOVER_CONTROL_ADDR, 16'h00C0, 16'hFFEF);
		$display("Test second reset done");
		wrap_up;
	end
endmodule
